//--- dv/interrupt_flag_enable_bank_bench.sv
// Self-checking bench for the interrupt flag and enable bank, large and small variants
`timescale 1ns/1ps
module interrupt_flag_enable_bank_bench;
  import irq_bank_pkg::*;

  logic clk_i;
  logic rst_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] small_dat;
  logic small_ack;
  logic [3:0] pin_i;
  src_events_type events_i;
  logic service_ack_i;
  logic irq_req_o;
  logic [3:0] vector_o;
  logic wake_o;
  int n_mismatch;
  int cmp_count;
  logic [31:0] rd;
  logic [31:0] rd2;
  src_events_type ev;
  // Implemented bits as documented, large then small variant
  logic [7:0] mask_big [8] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'hFF};
  logic [7:0] mask_small [8] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h33, 8'h77, 8'h33};

  interrupt_flag_enable_bank dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .events_i(events_i), .service_ack_i(service_ack_i),
    .irq_req_o(irq_req_o), .vector_o(vector_o), .wake_o(wake_o)
  );

  // Smaller variant shares every input, so each access exercises both
  interrupt_flag_enable_bank #(.FOUR_PINS(1'b0), .HAS_TIMER2(1'b0), .HAS_TIMER3(1'b0)) dut_small (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(small_dat),
    .wb_ack_o(small_ack), .pin_i(pin_i), .events_i(events_i), .service_ack_i(service_ack_i),
    .irq_req_o(), .vector_o(), .wake_o()
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task final_report;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic single cycle; no fixed latency assumed, bounded wait only
  task wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd, input logic [3:0] sel);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    wb_sel_i <= sel;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    rd2 = (small_ack === 1'b1) ? small_dat : 32'hDEADBEEF;
    check("ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task wr(input logic [7:0] adr, input logic [7:0] wd);
    wb_xfer(1'b1, adr, wd, 4'h1);
  endtask : wr

  task pulse(input src_events_type e);
    @(posedge clk_i);
    events_i <= e;
    @(posedge clk_i);
    events_i <= '0;
    #1;
  endtask : pulse

  task set_pin(input int idx, input logic v);
    @(posedge clk_i);
    pin_i[idx] <= v;
    repeat (5) @(posedge clk_i);
  endtask : set_pin

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    final_report;
  end

  initial begin
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    pin_i = 4'h0;
    events_i = '0;
    service_ack_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then all-ones write shows which bits exist in each variant
    for (int i = 0; i < 8; i++) begin
      wb_xfer(1'b0, 8'(i * 4), 8'h00, 4'h1);
      check("reset", rd, 32'h0);
      wr(8'(i * 4), 8'hFF);
      wb_xfer(1'b0, 8'(i * 4), 8'h00, 4'h1);
      check("mask_large", rd, {24'h0, mask_big[i]});
      check("mask_small", rd2, {24'h0, mask_small[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'(i * 4), 8'h00);
    end
    // Refused accesses: unmapped, misaligned, no byte lane
    wb_xfer(1'b0, 8'h20, 8'h00, 4'h1);
    check("unmapped", rd, 32'h0);
    wr(8'h21, 8'hFF);
    wb_xfer(1'b1, 8'h00, 8'hFF, 4'h0);
    wb_xfer(1'b0, 8'h00, 8'h00, 4'h1);
    check("edge_ignored", rd, 32'h0);
    // Each edge code on pin 0, rising then falling
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 8'(c));
      wr(8'h04, 8'h00);
      set_pin(0, 1'b1);
      wb_xfer(1'b0, 8'h04, 8'h00, 4'h1);
      check("rise_flag", rd, {27'h0, c[0], 4'h0});
      wr(8'h04, 8'h00);
      set_pin(0, 1'b0);
      wb_xfer(1'b0, 8'h04, 8'h00, 4'h1);
      check("fall_flag", rd, {27'h0, c[1], 4'h0});
    end
    // Pin 3 field sits at the top of the edge register
    wr(8'h00, 8'h40);
    set_pin(3, 1'b1);
    wb_xfer(1'b0, 8'h10, 8'h00, 4'h1);
    check("pin3_flag", rd, 32'h20);
    check("small_ctrl3", rd2, 32'h0);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h00);
    // Timer1 P match with every enable off sets flags; group enable without global raises no request
    ev = '0;
    ev.timer1_p = 1'b1;
    pulse(ev);
    check("wake", {31'h0, wake_o}, 32'h1);
    wb_xfer(1'b0, 8'h18, 8'h00, 4'h1);
    check("grp1", rd, 32'h10);
    wb_xfer(1'b0, 8'h08, 8'h00, 4'h1);
    check("group1_flag", rd, 32'h40);
    wr(8'h08, 8'h44);
    repeat (2) @(posedge clk_i);
    #1;
    check("no_global", {31'h0, irq_req_o}, 32'h0);
    wr(8'h04, 8'h01);
    repeat (2) @(posedge clk_i);
    #1;
    check("irq", {31'h0, irq_req_o}, 32'h1);
    check("vector", {28'h0, vector_o}, 32'h5);
    @(posedge clk_i);
    service_ack_i <= 1'b1;
    @(posedge clk_i);
    service_ack_i <= 1'b0;
    #1;
    check("irq_after", {31'h0, irq_req_o}, 32'h0);
    wb_xfer(1'b0, 8'h04, 8'h00, 4'h1);
    check("global_clr", rd, 32'h0);
    wb_xfer(1'b0, 8'h08, 8'h00, 4'h1);
    check("grp_flag_clr", rd, 32'h04);
    // A flag already set raises no second wake
    ev = '0;
    ev.comparator[0] = 1'b1;
    pulse(ev);
    check("wake_new", {31'h0, wake_o}, 32'h1);
    pulse(ev);
    check("wake_again", {31'h0, wake_o}, 32'h0);
    // Two enabled sources pending: pin 0 outranks conversion
    wr(8'h08, 8'h88);
    wr(8'h04, 8'h13);
    repeat (2) @(posedge clk_i);
    #1;
    check("prio_vector", {28'h0, vector_o}, 32'h0);
    // Global on, pin 0 flag without its own enable: nothing requested
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h11);
    repeat (2) @(posedge clk_i);
    #1;
    check("pin0_en_off", {31'h0, irq_req_o}, 32'h0);
    wr(8'h04, 8'h49);
    repeat (2) @(posedge clk_i);
    #1;
    check("cmp0_vector", {28'h0, vector_o}, 32'h2);
    // Time base, conversion and group members flag with enables off
    wr(8'h04, 8'h00);
    ev = '0;
    ev.timebase[0] = 1'b1;
    ev.conv_done = 1'b1;
    ev.timer0_a = 1'b1;
    ev.serial_module = 1'b1;
    ev.group3_member = 1'b1;
    pulse(ev);
    check("tb_wake", {31'h0, wake_o}, 32'h1);
    wb_xfer(1'b0, 8'h0C, 8'h00, 4'h1);
    check("ctrl2_flags", rd, 32'hB0);
    wb_xfer(1'b0, 8'h08, 8'h00, 4'h1);
    check("ctrl1_flags", rd, 32'hA0);
    wb_xfer(1'b0, 8'h14, 8'h00, 4'h1);
    check("t0a_flag", rd, 32'h20);
    wb_xfer(1'b0, 8'h1C, 8'h00, 4'h1);
    check("serial_flag", rd, 32'h10);
    // Comparator 1 event in the very cycle a clearing write lands
    ev = '0;
    ev.comparator[1] = 1'b1;
    fork
      wr(8'h08, 8'h00);
      begin
        @(posedge clk_i);
        pulse(ev);
      end
    join
    wb_xfer(1'b0, 8'h08, 8'h00, 4'h1);
    check("set_wins", rd, 32'h10);
    final_report;
  end
endmodule : interrupt_flag_enable_bank_bench

//--- hdl/interrupt_flag_enable_bank.sv
// Interrupt request flag and enable bank with edge-selected pins and a classic Wishbone slave
// Summary of operation
// - Edge code 00 off, 01 rising, 10 falling, 11 both edges set pin flag.
// - Largest variant edge register: pin3 bits 7-6 down to pin0 bits 1-0.
// - Smaller variants keep only pin0 and pin1 fields; upper nibble reads zero.
// - Bit 0 of control register 0 is global enable; zero blocks all interrupts.
// - Flags read 1 while a request is pending and are software writable.
// - Enable bit 1 enables its source; enables mirror flags in low nibble, one bit higher in control 0.
// - Unimplemented bits read zero and ignore writes.
// - Control 0: comparator0, pin1, pin0 flags bits 6-4, enables bits 3-1.
// - Control 1: conversion, group1, group0, comparator1 flags bits 7-4, enables below.
// - Control 2: group3, timebase1, timebase0, group2 flags bits 7-4, enables below.
// - Largest variant control 3: pin3, pin2 flags bits 5-4, enables 1-0.
// - Group 0: timer0 A,P bits 5-4; timer2 A,P bits 7-6 where present.
// - Group 1: timer1 B, A, P flags bits 6-4, enables bits 2-0.
// - Group 2: peripheral pin bit 5, serial bit 4; timer3 A,P bits 7-6.
// - Group 3 flag at control 2 bit 7, enable bit 3, gates its vector.
// - Flags set regardless of enable; vector needs source and global enable.
// - Group flag sets whenever any member flag rises.
// - Service clears global enable and the serviced flag, blocking nesting.
// - A newly set flag wakes the device; a flag already set does not.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module interrupt_flag_enable_bank
  import irq_bank_pkg::*;
#(
  parameter bit FOUR_PINS = 1'b1,
  parameter bit HAS_TIMER2 = 1'b1,
  parameter bit HAS_TIMER3 = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_WIDTH-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_PINS-1:0] pin_i,
  input wire src_events_type events_i,
  input wire logic service_ack_i,
  output logic irq_req_o,
  output logic [3:0] vector_o,
  output logic wake_o
);

  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic [7:0] hw_set [NUM_REGS];
  logic [7:0] svc_clr [NUM_REGS];
  logic [7:0] impl_mask [NUM_REGS];
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic [NUM_PINS-1:0] pin_prev_reg;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic [NUM_PINS-1:0] edge_hit;
  logic [NUM_SRC-1:0] pend;
  logic [3:0] pend_first;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic irq_req_reg;
  logic [3:0] vector_reg;
  logic wake_reg;
  logic access;
  logic mapped;
  logic [2:0] idx;
  logic wr_fire;
  logic svc_fire;
  logic global_en;
  logic [NUM_GROUPS-1:0] grp_rise;

  // Implemented-bit masks by variant
  always_comb begin
    impl_mask[REG_EDGE] = FOUR_PINS ? MASK_EDGE_LARGE : MASK_EDGE_SMALL;
    impl_mask[REG_CTRL0] = MASK_CTRL0;
    impl_mask[REG_CTRL1] = MASK_FULL;
    impl_mask[REG_CTRL2] = MASK_FULL;
    impl_mask[REG_CTRL3] = FOUR_PINS ? MASK_CTRL3 : MASK_NONE;
    impl_mask[REG_GRP0] = HAS_TIMER2 ? MASK_FULL : MASK_LOW_PAIR;
    impl_mask[REG_GRP1] = MASK_GRP1;
    impl_mask[REG_GRP2] = HAS_TIMER3 ? MASK_FULL : MASK_LOW_PAIR;
  end

  // Bus decode; only the low byte lane carries register data
  assign idx = wb_adr_i[ADR_IDX_MSB:ADR_IDX_LSB];
  assign mapped = (wb_adr_i[ADR_WIDTH-1:ADR_IDX_MSB+1] == '0) && (wb_adr_i[ADR_IDX_LSB-1:0] == '0);
  assign access = wb_cyc_i && wb_stb_i;
  // Write lands on the edge where ack is high, matching the master's sample
  assign wr_fire = access && wb_we_i && ack_reg && mapped && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= '0;
    end else if (access && !ack_reg) begin
      dat_reg <= mapped ? {24'h000000, regs_reg[idx] & impl_mask[idx]} : '0;
    end
  end

  // Pin synchronisers: meta stage feeds only the sync stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_edge
    logic [1:0] sel;
    assign sel = regs_reg[REG_EDGE][2*g+1:2*g] & impl_mask[REG_EDGE][2*g+1:2*g];
    assign edge_hit[g] = ((sel == EDGE_RISE || sel == EDGE_BOTH) && pin_rise[g]) ||
                         ((sel == EDGE_FALL || sel == EDGE_BOTH) && pin_fall[g]);
  end

  // Pending vector requests
  assign global_en = regs_reg[REG_CTRL0][BIT_GLOBAL_EN];
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_pend
    // Control 0 enables sit three below their flags, all others four
    localparam logic [2:0] EN_GAP = (SRC_REG[s] == REG_CTRL0) ? FLAG_TO_EN_CTRL0 : FLAG_TO_EN;
    assign pend[s] = regs_reg[SRC_REG[s]][SRC_BIT[s]] &&
                     regs_reg[SRC_REG[s]][SRC_BIT[s] - EN_GAP] && global_en;
  end

  always_comb begin
    pend_first = VECTOR_IDLE;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (pend[s]) begin
        pend_first = 4'(s);
      end
    end
  end

  assign svc_fire = service_ack_i && irq_req_reg;

  // Service clears: global enable plus the flag behind the vector shown
  always_comb begin
    for (int r = 0; r < NUM_REGS; r++) begin
      svc_clr[r] = '0;
    end
    if (svc_fire) begin
      svc_clr[REG_CTRL0][BIT_GLOBAL_EN] = 1'b1;
      svc_clr[SRC_REG[vector_reg]][SRC_BIT[vector_reg]] = 1'b1;
    end
  end

  // Hardware set requests; group flags come from member rises
  always_comb begin
    for (int r = 0; r < NUM_REGS; r++) begin
      hw_set[r] = '0;
    end
    hw_set[REG_CTRL0][BIT_CMP0_FLAG] = events_i.comparator[0];
    hw_set[REG_CTRL0][BIT_PIN1_FLAG] = edge_hit[1];
    hw_set[REG_CTRL0][BIT_PIN0_FLAG] = edge_hit[0];
    hw_set[REG_CTRL1][BIT_CONV_FLAG] = events_i.conv_done;
    hw_set[REG_CTRL1][BIT_GRP1_FLAG] = grp_rise[1];
    hw_set[REG_CTRL1][BIT_GRP0_FLAG] = grp_rise[0];
    hw_set[REG_CTRL1][BIT_CMP1_FLAG] = events_i.comparator[1];
    hw_set[REG_CTRL2][BIT_GRP3_FLAG] = grp_rise[3];
    hw_set[REG_CTRL2][BIT_TB1_FLAG] = events_i.timebase[1];
    hw_set[REG_CTRL2][BIT_TB0_FLAG] = events_i.timebase[0];
    hw_set[REG_CTRL2][BIT_GRP2_FLAG] = grp_rise[2];
    hw_set[REG_CTRL3][BIT_PIN3_FLAG] = edge_hit[3];
    hw_set[REG_CTRL3][BIT_PIN2_FLAG] = edge_hit[2];
    hw_set[REG_GRP0][BIT_T2A_FLAG] = events_i.timer2_a;
    hw_set[REG_GRP0][BIT_T2P_FLAG] = events_i.timer2_p;
    hw_set[REG_GRP0][BIT_T0A_FLAG] = events_i.timer0_a;
    hw_set[REG_GRP0][BIT_T0P_FLAG] = events_i.timer0_p;
    hw_set[REG_GRP1][BIT_T1B_FLAG] = events_i.timer1_b;
    hw_set[REG_GRP1][BIT_T1A_FLAG] = events_i.timer1_a;
    hw_set[REG_GRP1][BIT_T1P_FLAG] = events_i.timer1_p;
    hw_set[REG_GRP2][BIT_T3A_FLAG] = events_i.timer3_a;
    hw_set[REG_GRP2][BIT_T3P_FLAG] = events_i.timer3_p;
    hw_set[REG_GRP2][BIT_PERIPH_FLAG] = events_i.periph_pin;
    hw_set[REG_GRP2][BIT_SERIAL_FLAG] = events_i.serial_module;
  end

  // Next values: write, then service clear, then hardware set so the event wins
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_next
    logic [7:0] written;
    assign written = (wr_fire && idx == 3'(r)) ? wb_dat_i[7:0] : regs_reg[r];
    assign regs_next[r] = ((written & ~svc_clr[r]) | hw_set[r]) & impl_mask[r];
  end

  // Member flags rising, including a software set, raise their group
  always_comb begin
    grp_rise[0] = |(regs_next[REG_GRP0] & ~regs_reg[REG_GRP0] & FLAG_NIBBLE);
    grp_rise[1] = |(regs_next[REG_GRP1] & ~regs_reg[REG_GRP1] & FLAG_NIBBLE);
    grp_rise[2] = |(regs_next[REG_GRP2] & ~regs_reg[REG_GRP2] & FLAG_NIBBLE);
    grp_rise[3] = events_i.group3_member;
  end

  for (genvar r = 0; r < NUM_REGS; r++) begin : g_regs
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs_reg[r] <= REG_RESET;
      end else begin
        regs_reg[r] <= regs_next[r];
      end
    end
  end

  // Vector request; dropped on the service cycle to avoid a stale repeat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_reg <= 1'b0;
      vector_reg <= VECTOR_IDLE;
    end else begin
      irq_req_reg <= (|pend) && !svc_fire;
      vector_reg <= svc_fire ? VECTOR_IDLE : pend_first;
    end
  end

  // Wake pulse only on a 0 to 1 flag transition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |((regs_next[REG_CTRL0] & ~regs_reg[REG_CTRL0] & FLAG_NIBBLE) |
                    (regs_next[REG_CTRL1] & ~regs_reg[REG_CTRL1] & FLAG_NIBBLE) |
                    (regs_next[REG_CTRL2] & ~regs_reg[REG_CTRL2] & FLAG_NIBBLE) |
                    (regs_next[REG_CTRL3] & ~regs_reg[REG_CTRL3] & FLAG_NIBBLE) |
                    (regs_next[REG_GRP0] & ~regs_reg[REG_GRP0] & FLAG_NIBBLE) |
                    (regs_next[REG_GRP1] & ~regs_reg[REG_GRP1] & FLAG_NIBBLE) |
                    (regs_next[REG_GRP2] & ~regs_reg[REG_GRP2] & FLAG_NIBBLE));
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_req_o = irq_req_reg;
  assign vector_o = vector_reg;
  assign wake_o = wake_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_GLOBAL_GATE: assert property (
    !global_en |=> !irq_req_o)
    else $error("Interrupt requested while global enable was clear");

  AST_RISE_SETS: assert property (
    (pin_rise[0] && regs_reg[REG_EDGE][1:0] == EDGE_RISE) |=> regs_reg[REG_CTRL0][BIT_PIN0_FLAG])
    else $error("Rising edge did not set pin 0 flag");

  AST_FALL_IGNORED: assert property (
    (pin_fall[1] && !pin_rise[1] && regs_reg[REG_EDGE][3:2] == EDGE_RISE &&
     !regs_reg[REG_CTRL0][BIT_PIN1_FLAG] && !wr_fire) |=> !regs_reg[REG_CTRL0][BIT_PIN1_FLAG])
    else $error("Falling edge set pin 1 flag under rising-only select");

  AST_PIN_LATENCY: assert property (
    ($rose(pin_sync_reg[0]) && regs_reg[REG_EDGE][1:0] == EDGE_BOTH) ##1
     (regs_reg[REG_EDGE][1:0] == EDGE_BOTH) |-> regs_reg[REG_CTRL0][BIT_PIN0_FLAG])
    else $error("Synchronised pin edge not flagged one cycle later");

  AST_UNIMPL_ZERO: assert property (
    regs_reg[REG_CTRL0][7] == 1'b0 && regs_reg[REG_GRP1][7] == 1'b0 &&
    (regs_reg[REG_CTRL3] & ~MASK_CTRL3) == '0)
    else $error("Unimplemented bit holds a one");

  AST_SMALL_EDGE: assert property (
    !FOUR_PINS |-> regs_reg[REG_EDGE][7:4] == 4'h0 && regs_reg[REG_CTRL3] == '0)
    else $error("Small variant holds upper edge fields");

  AST_FLAG_DISABLED: assert property (
    events_i.conv_done |=> regs_reg[REG_CTRL1][BIT_CONV_FLAG])
    else $error("Conversion event did not set its flag");

  AST_GROUP_SET: assert property (
    (events_i.timer1_p && !regs_reg[REG_GRP1][BIT_T1P_FLAG]) |=>
     regs_reg[REG_GRP1][BIT_T1P_FLAG] && regs_reg[REG_CTRL1][BIT_GRP1_FLAG])
    else $error("Timer 1 P match did not set member and group flags");

  AST_SERVICE_CLEAR: assert property (
    svc_fire |=> !global_en && !irq_req_o ##1 !irq_req_o)
    else $error("Service did not clear global enable and request");

  AST_WAKE_NEW: assert property (
    (events_i.timebase[0] && !regs_reg[REG_CTRL2][BIT_TB0_FLAG]) |=> wake_o)
    else $error("New time base flag did not wake");

  AST_WAKE_OLD: assert property (
    $stable(regs_reg[REG_CTRL2]) && $stable(regs_reg[REG_CTRL1]) && $stable(regs_reg[REG_CTRL0]) &&
    $stable(regs_reg[REG_CTRL3]) && $stable(regs_reg[REG_GRP0]) && $stable(regs_reg[REG_GRP1]) &&
    $stable(regs_reg[REG_GRP2]) |-> !wake_o)
    else $error("Wake pulse with no flag change");

  AST_SET_WINS: assert property (
    (wr_fire && idx == REG_CTRL1 && wb_dat_i[BIT_CMP1_FLAG] == 1'b0 && events_i.comparator[1]) |=>
     regs_reg[REG_CTRL1][BIT_CMP1_FLAG])
    else $error("Software clear beat hardware set");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");

  AST_ACK_ANSWER: assert property (
    (access && !wb_ack_o) |=> wb_ack_o)
    else $error("Request not acknowledged in the next cycle");

  AST_EDGE_OFF: assert property (
    ((pin_rise[0] || pin_fall[0]) && regs_reg[REG_EDGE][1:0] == EDGE_OFF &&
     !regs_reg[REG_CTRL0][BIT_PIN0_FLAG] && !wr_fire) |=> !regs_reg[REG_CTRL0][BIT_PIN0_FLAG])
    else $error("Pin 0 edge set its flag while triggering was off");

  AST_FALL_SETS: assert property (
    (pin_fall[0] && regs_reg[REG_EDGE][1:0] == EDGE_FALL) |=> regs_reg[REG_CTRL0][BIT_PIN0_FLAG])
    else $error("Falling edge did not set pin 0 flag");

  AST_PIN3_RISE: assert property (
    (FOUR_PINS && pin_rise[3] && regs_reg[REG_EDGE][7:6] == EDGE_RISE) |=> regs_reg[REG_CTRL3][BIT_PIN3_FLAG])
    else $error("Rising edge on pin 3 did not set its flag");

  AST_MASK_HELD: assert property (
    (regs_reg[REG_EDGE] & ~impl_mask[REG_EDGE]) == '0 && (regs_reg[REG_GRP0] & ~impl_mask[REG_GRP0]) == '0 &&
    (regs_reg[REG_GRP2] & ~impl_mask[REG_GRP2]) == '0)
    else $error("Bit outside the variant layout holds a one");

  AST_READ_UPPER: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == '0)
    else $error("Read data above the low byte is not zero");

  AST_WRITE_LANDS: assert property (
    (wr_fire && idx == REG_CTRL2 && events_i == '0 && !svc_fire) |=>
     regs_reg[REG_CTRL2] == $past(wb_dat_i[7:0]))
    else $error("Write to control register 2 did not land");

  AST_PIN0_ENABLE: assert property (
    (regs_reg[REG_CTRL0][BIT_CMP0_FLAG:BIT_PIN1_FLAG] == '0 && !regs_reg[REG_CTRL0][BIT_PIN0_EN] &&
     regs_reg[REG_CTRL1] == '0 && regs_reg[REG_CTRL2] == '0 && regs_reg[REG_CTRL3] == '0) |=> !irq_req_o)
    else $error("Request raised while pin 0 enable was clear");

  AST_CMP0_VECTOR: assert property (
    (regs_reg[REG_CTRL0][BIT_CMP0_FLAG] && regs_reg[REG_CTRL0][BIT_CMP0_EN] && global_en &&
     regs_reg[REG_CTRL0][BIT_PIN1_FLAG:BIT_PIN0_FLAG] == '0 && !svc_fire) |=> irq_req_o && vector_o == 4'h2)
    else $error("Enabled comparator 0 flag did not raise its vector");

  AST_SERVICE_FLAG: assert property (
    (svc_fire && vector_o == 4'h5 && !grp_rise[1]) |=> !regs_reg[REG_CTRL1][BIT_GRP1_FLAG])
    else $error("Serviced group 1 flag not cleared");

  AST_GROUP0_SET: assert property (
    (events_i.timer0_a && !regs_reg[REG_GRP0][BIT_T0A_FLAG]) |=> regs_reg[REG_CTRL1][BIT_GRP0_FLAG])
    else $error("Timer 0 A match did not set group 0 flag");

  AST_GROUP2_SET: assert property (
    (events_i.serial_module && !regs_reg[REG_GRP2][BIT_SERIAL_FLAG]) |=>
     regs_reg[REG_GRP2][BIT_SERIAL_FLAG] && regs_reg[REG_CTRL2][BIT_GRP2_FLAG])
    else $error("Serial event did not set member and group 2 flags");

  AST_GROUP3_SET: assert property (
    events_i.group3_member |=> regs_reg[REG_CTRL2][BIT_GRP3_FLAG])
    else $error("Group 3 member did not set group 3 flag");

  AST_TIMEBASE_SET: assert property (
    events_i.timebase[0] |=> regs_reg[REG_CTRL2][BIT_TB0_FLAG])
    else $error("Time base 0 event did not set its flag");

endmodule : interrupt_flag_enable_bank

//--- hdl/irq_bank_pkg.sv
// Constants, field layouts and carrier types for the interrupt flag and enable bank
package irq_bank_pkg;

  localparam int NUM_REGS = 8;
  localparam int NUM_PINS = 4;
  localparam int NUM_SRC = 13;
  localparam int NUM_GROUPS = 4;

  // Register index; byte address is index times four
  localparam logic [2:0] REG_EDGE = 3'h0;
  localparam logic [2:0] REG_CTRL0 = 3'h1;
  localparam logic [2:0] REG_CTRL1 = 3'h2;
  localparam logic [2:0] REG_CTRL2 = 3'h3;
  localparam logic [2:0] REG_CTRL3 = 3'h4;
  localparam logic [2:0] REG_GRP0 = 3'h5;
  localparam logic [2:0] REG_GRP1 = 3'h6;
  localparam logic [2:0] REG_GRP2 = 3'h7;
  localparam int ADR_WIDTH = 8;
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_MSB = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Enable sits this many bits below its flag
  localparam logic [2:0] FLAG_TO_EN = 3'h4;
  localparam logic [7:0] FLAG_NIBBLE = 8'hF0;
  // Control 0 enables sit one bit higher because bit 0 is the global enable
  localparam logic [2:0] FLAG_TO_EN_CTRL0 = 3'h3;
  localparam int BIT_CMP0_EN = 3;
  localparam int BIT_PIN0_EN = 1;

  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_CMP0_FLAG = 6;
  localparam int BIT_PIN1_FLAG = 5;
  localparam int BIT_PIN0_FLAG = 4;
  localparam int BIT_CONV_FLAG = 7;
  localparam int BIT_GRP1_FLAG = 6;
  localparam int BIT_GRP0_FLAG = 5;
  localparam int BIT_CMP1_FLAG = 4;
  localparam int BIT_GRP3_FLAG = 7;
  localparam int BIT_TB1_FLAG = 6;
  localparam int BIT_TB0_FLAG = 5;
  localparam int BIT_GRP2_FLAG = 4;
  localparam int BIT_PIN3_FLAG = 5;
  localparam int BIT_PIN2_FLAG = 4;
  localparam int BIT_T2A_FLAG = 7;
  localparam int BIT_T2P_FLAG = 6;
  localparam int BIT_T0A_FLAG = 5;
  localparam int BIT_T0P_FLAG = 4;
  localparam int BIT_T1B_FLAG = 6;
  localparam int BIT_T1A_FLAG = 5;
  localparam int BIT_T1P_FLAG = 4;
  localparam int BIT_T3A_FLAG = 7;
  localparam int BIT_T3P_FLAG = 6;
  localparam int BIT_PERIPH_FLAG = 5;
  localparam int BIT_SERIAL_FLAG = 4;

  // Implemented bits per register and variant
  localparam logic [7:0] MASK_EDGE_SMALL = 8'h0F;
  localparam logic [7:0] MASK_EDGE_LARGE = 8'hFF;
  localparam logic [7:0] MASK_CTRL0 = 8'h7F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_CTRL3 = 8'h33;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_LOW_PAIR = 8'h33;
  localparam logic [7:0] MASK_GRP1 = 8'h77;

  // Edge-select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Vectored sources in priority order, highest first
  localparam logic [2:0] SRC_REG [NUM_SRC] = '{
    REG_CTRL0, REG_CTRL0, REG_CTRL0, REG_CTRL1, REG_CTRL1, REG_CTRL1, REG_CTRL1,
    REG_CTRL2, REG_CTRL2, REG_CTRL2, REG_CTRL2, REG_CTRL3, REG_CTRL3};
  localparam logic [2:0] SRC_BIT [NUM_SRC] = '{
    3'h4, 3'h5, 3'h6, 3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5};
  localparam logic [3:0] VECTOR_IDLE = 4'hF;

  // One-cycle source events, same clock as the bank
  typedef struct packed {
    logic [1:0] comparator;
    logic conv_done;
    logic [1:0] timebase;
    logic timer0_p;
    logic timer0_a;
    logic timer1_p;
    logic timer1_a;
    logic timer1_b;
    logic timer2_p;
    logic timer2_a;
    logic timer3_p;
    logic timer3_a;
    logic periph_pin;
    logic serial_module;
    logic group3_member;
  } src_events_type;

endpackage : irq_bank_pkg
